// ==== hdl/vec_pkg.sv ====
// constants and types for the video encoder mode-control register bank
// assumes: one 10 MHz clock, synchronous active-high reset
`default_nettype none
package vec_pkg;

    // register subaddresses on the two-wire port
    localparam logic [7:0] SUB_SFS      = 8'h00;
    localparam logic [7:0] SUB_OMC      = 8'h01;
    localparam logic [7:0] SUB_GVC      = 8'h02;
    localparam logic [7:0] SUB_DTC      = 8'h03;
    localparam logic [7:0] RD_UNMAPPED  = 8'h00;

    // reset values
    localparam logic [7:0] SFS_RST      = 8'h00;
    localparam logic [7:0] OMC_RST      = 8'h00;
    localparam logic [7:0] GVC_RST      = 8'h00;
    localparam logic [7:0] DTC_RST      = 8'h00;
    localparam logic [7:0] DTC_WR_MASK  = 8'hfc;

    // standard_filter_select fields
    localparam int         STD_LO       = 0;
    localparam logic [1:0] STD_NTSC     = 2'h0;

    // output_mode_control fields
    localparam int         INTERLACE_B  = 0;
    localparam int         CAP_LO       = 1;
    localparam int         PD_C_B       = 3;
    localparam int         PD_D_B       = 4;
    localparam int         PD_B_B       = 5;
    localparam int         PD_A_B       = 6;
    localparam int         COLOR_BAR_B  = 7;

    // genlock_video_control fields
    localparam int         SQUARE_B     = 0;
    localparam int         GL_INPUT_B   = 1;
    localparam int         GL_TYPE_B    = 2;
    localparam int         LINE_LEN_B   = 3;
    localparam int         CHROMA_B     = 4;
    localparam int         BURST_B      = 5;

    // dac_teletext_control fields
    localparam int         VBI_B        = 2;
    localparam int         DAC_SW_B     = 3;
    localparam int         DAC4_B       = 4;
    localparam int         TTX_EN_B     = 5;
    localparam int         TTX_MODE_B   = 6;
    localparam int         DEF_COLOR_B  = 7;

    // caption field codes
    localparam logic [1:0] CAP_ODD      = 2'h1;
    localparam logic [1:0] CAP_EVEN     = 2'h2;
    localparam logic [1:0] CAP_BOTH     = 2'h3;

    // active pixels per line
    localparam logic [9:0] PIX_DIGITAL  = 10'h2d0;
    localparam logic [9:0] PIX_AN_NTSC  = 10'h2c6;
    localparam logic [9:0] PIX_AN_PAL   = 10'h2be;

    // colour bar levels in tenths of a percent
    localparam logic [9:0] LVL_75       = 10'h2ee;
    localparam logic [9:0] LVL_7P5      = 10'h04b;
    localparam logic [9:0] LVL_100      = 10'h3e8;
    localparam logic [9:0] LVL_0        = 10'h000;

    // dac source codes
    localparam logic [2:0] SRC_OFF      = 3'h0;
    localparam logic [2:0] SRC_CVBS     = 3'h1;
    localparam logic [2:0] SRC_BLUE_U   = 3'h2;
    localparam logic [2:0] SRC_RED_V    = 3'h3;
    localparam logic [2:0] SRC_GREEN_Y  = 3'h4;
    localparam logic [2:0] SRC_CHROMA   = 3'h5;

    localparam logic [2:0] BYTE_LAST    = 3'h7;
    localparam logic       SDA_LOW      = 1'b0;
    localparam logic       PIN_IDLE     = 1'b0;
    localparam logic       LINE_IDLE    = 1'b1;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } vec_link_e;

endpackage : vec_pkg
`default_nettype wire

// ==== hdl/vec_dac_slot.sv ====
// one dac output slot: registered source select with power-down
// assumes: source code chosen by the mode-control block
`timescale 1ns/1ps
`default_nettype none
module vec_dac_slot
    import vec_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [2:0] i_src,
    input  wire logic       i_power_down,
    output logic      [2:0] o_src,
    output logic            o_power_on
);

    typedef struct packed {
        logic [2:0] src;
        logic       on;
    } vec_slot_s;

    vec_slot_s q;
    vec_slot_s n;

    always_comb begin
        n    = q;
        n.on = ~i_power_down;                                  // R4
        n.src = i_power_down ? SRC_OFF : i_src;                // R3
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign o_src      = q.src;
    assign o_power_on = q.on;

    AST_DAC_OFF: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_power_down |=> (!o_power_on && o_src == SRC_OFF)) // R4
        else $error("powered-down dac still on");

endmodule // vec_dac_slot
`default_nettype wire

// ==== hdl/vec_mode_ctrl.sv ====
// mode-control register bank of a pal/ntsc video encoder
// assumes: two-wire serial lines sampled on i_clk (10 MHz, far faster
// than the serial clock); sda is open drain, bus pull-up outside
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Operation
// R1: interlace select acts only while composite output mode is active
// R2: caption field select picks odd, even or both fields
// R3: four dac power-down bits, one per dac
// R4: power-down bit 0 keeps dac on, 1 switches it off
// R5: colour bar bit makes test bars, ntsc 75/7.5/75/7.5, pal 100/0/75/0
// R6: colour bars force master timing whatever the master select
// R7: square pixel only in slave mode; host supplies matching clock
// R8: genlock input enable 1 turns the shared pin into an input
// R9: genlock type 0: pin falling edge resets subcarrier to field 0
// R10: genlock type 1: pin is a real-time control input
// R11: line length 0 gives 720 pixels, 1 gives 710 ntsc or 702 pal
// R12: chrominance enable gates colour information
// R13: burst enable gates colour burst
// R14: two revision bits read only, writes ignored
// R15: vbi pass-through passes or blanks vertical blanking data
// R16: dac switching bit selects scart-style output arrangement
// R17: in yuv output fourth dac carries composite at 0, chroma at 1
// R18: teletext inserted only while teletext enable is 1
// R19: request mode 0 holds request high, 1 gives bitwise request
// R20: zero pixels show code 00000000 colour at 0, black at 1
module vec_mode_ctrl
    import vec_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR  = 7'h6a,
    parameter logic [1:0] REV_CODE  = 2'h1  // arbitrary value
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe,
    input  wire logic        i_composite_mode,
    input  wire logic        i_yuv_mode,
    input  wire logic        i_master_select,
    input  wire logic        i_scr_pin,
    output logic             o_scr_pin_out,
    output logic             o_scr_pin_oe,
    input  wire logic        i_ttx_pin,
    input  wire logic        i_ttx_bit_req,
    output logic             o_ttx_request,
    output logic             o_ttx_data,
    output logic             o_interlace_en,
    output logic             o_caption_odd,
    output logic             o_caption_even,
    output logic [3:0][2:0]  o_dac_src,
    output logic [3:0]       o_dac_power_on,
    output logic             o_color_bar_en,
    output logic [3:0][9:0]  o_bar_levels,
    output logic             o_master_mode,
    output logic             o_square_pixel,
    output logic             o_subcarrier_reset,
    output logic             o_rtc_valid,
    output logic             o_rtc_data,
    output logic [9:0]       o_active_pixels,
    output logic             o_chroma_en,
    output logic             o_burst_en,
    output logic             o_vbi_pass,
    output logic             o_zero_is_black
);

    typedef struct packed {
        vec_link_e  st;
        logic [7:0] sh;
        logic [2:0] cnt;
        logic       done;
        logic       rw;
        logic       nack;
        logic [7:0] ptr;
        logic       sda_oe;
        logic       scl_q;
        logic       sda_q;
        logic       pin_q;
        logic [7:0] sfs;
        logic [7:0] omc;
        logic [7:0] gvc;
        logic [7:0] dtc;
        logic       interlace;
        logic       cap_odd;
        logic       cap_even;
        logic       master;
        logic       square;
        logic       pin_oe;
        logic       sc_reset;
        logic       rtc_valid;
        logic       rtc_data;
        logic       ttx_data;
    } vec_state_s;

    vec_state_s q;
    vec_state_s n;

    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic [7:0] rd_data;
    logic       is_ntsc;
    logic [1:0] cap_sel;
    logic       gl_input;
    logic       gl_type;
    logic       ttx_en;
    logic [3:0][2:0] dac_route;
    logic [3:0]      dac_pd;

    ////////////////////////////////////////////////////////////////////
    // two-wire link conditions, from the previous sample of each line
    assign scl_rise  = i_scl & ~q.scl_q;
    assign scl_fall  = ~i_scl & q.scl_q;
    assign bus_start = i_scl & q.scl_q & q.sda_q & ~i_sda;
    assign bus_stop  = i_scl & q.scl_q & ~q.sda_q & i_sda;

    // revision bits come from the parameter, never from storage
    assign rd_data = (q.ptr == SUB_SFS) ? q.sfs :
                     (q.ptr == SUB_OMC) ? q.omc :
                     (q.ptr == SUB_GVC) ? q.gvc :
                     (q.ptr == SUB_DTC) ? {q.dtc[7:2], REV_CODE} : // R14
                     RD_UNMAPPED;

    assign is_ntsc  = (q.sfs[STD_LO +: 2] == STD_NTSC);
    assign cap_sel  = q.omc[CAP_LO +: 2];
    assign gl_input = q.gvc[GL_INPUT_B];
    assign gl_type  = q.gvc[GL_TYPE_B];
    assign ttx_en   = q.dtc[TTX_EN_B];

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        n       = q;
        n.scl_q = i_scl;
        n.sda_q = i_sda;
        n.pin_q = i_scr_pin;
        if (bus_stop) begin
            n.st     = ST_IDLE;
            n.sda_oe = 1'b0;
        end else if (bus_start) begin
            n.st     = ST_ADDR;
            n.cnt    = '0;
            n.done   = 1'b0;
            n.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (q.st)
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    n.sh   = {q.sh[6:0], i_sda};
                    n.cnt  = q.cnt + 3'h1;
                    n.done = (q.cnt == BYTE_LAST);
                end
                ST_RDATA_ACK: begin
                    n.nack = i_sda;
                end
                default: begin
                    n.nack = q.nack;
                end
            endcase
        end else if (scl_fall) begin
            // sda only changes while scl is low
            case (q.st)
                ST_ADDR: begin
                    if (q.done) begin
                        n.done = 1'b0;
                        if (q.sh[7:1] == DEV_ADDR) begin
                            n.rw     = q.sh[0];
                            n.st     = ST_ADDR_ACK;
                            n.sda_oe = 1'b1;
                        end else begin
                            n.st = ST_IDLE;
                        end
                    end
                end
                ST_SUB: begin
                    if (q.done) begin
                        n.done   = 1'b0;
                        n.ptr    = q.sh;
                        n.st     = ST_SUB_ACK;
                        n.sda_oe = 1'b1;
                    end
                end
                ST_WDATA: begin
                    if (q.done) begin
                        n.done = 1'b0;
                        case (q.ptr)
                            SUB_SFS: n.sfs = q.sh;
                            SUB_OMC: n.omc = q.sh;
                            SUB_GVC: n.gvc = q.sh;
                            SUB_DTC: n.dtc = q.sh & DTC_WR_MASK;  // R14
                            default: n.sfs = q.sfs;
                        endcase
                        n.ptr    = q.ptr + 8'h01;
                        n.st     = ST_WDATA_ACK;
                        n.sda_oe = 1'b1;
                    end
                end
                ST_ADDR_ACK: begin
                    n.cnt = '0;
                    if (q.rw) begin
                        n.st     = ST_RDATA;
                        n.sh     = rd_data;
                        n.ptr    = q.ptr + 8'h01;
                        n.sda_oe = ~rd_data[7];
                    end else begin
                        n.st     = ST_SUB;
                        n.sda_oe = 1'b0;
                    end
                end
                ST_SUB_ACK, ST_WDATA_ACK: begin
                    n.st     = ST_WDATA;
                    n.cnt    = '0;
                    n.sda_oe = 1'b0;
                end
                ST_RDATA: begin
                    if (q.cnt == BYTE_LAST) begin
                        n.st     = ST_RDATA_ACK;
                        n.sda_oe = 1'b0;
                    end else begin
                        n.sh     = {q.sh[6:0], 1'b0};
                        n.cnt    = q.cnt + 3'h1;
                        n.sda_oe = ~q.sh[6];
                    end
                end
                ST_RDATA_ACK: begin
                    // host nack ends the read burst
                    if (q.nack) begin
                        n.st = ST_IDLE;
                    end else begin
                        n.st     = ST_RDATA;
                        n.sh     = rd_data;
                        n.ptr    = q.ptr + 8'h01;
                        n.cnt    = '0;
                        n.sda_oe = ~rd_data[7];
                    end
                end
                default: begin
                    n.st = ST_IDLE;
                end
            endcase
        end

        // video-side controls
        n.interlace = q.omc[INTERLACE_B] & i_composite_mode;      // R1
        n.cap_odd   = (cap_sel == CAP_ODD) | (cap_sel == CAP_BOTH); // R2
        n.cap_even  = (cap_sel == CAP_EVEN) | (cap_sel == CAP_BOTH); // R2
        n.master    = q.omc[COLOR_BAR_B] | i_master_select;       // R6
        n.square    = q.gvc[SQUARE_B] & ~n.master;                // R7
        n.pin_oe    = ~gl_input;                                  // R8
        n.sc_reset  = gl_input & ~gl_type & q.pin_q & ~i_scr_pin; // R9
        n.rtc_valid = gl_input & gl_type;                         // R10
        n.rtc_data  = gl_input & gl_type & i_scr_pin;             // R10
        n.ttx_data  = ttx_en & i_ttx_pin;                         // R18
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q       <= '0;
            q.st    <= ST_IDLE;
            // lines idle high; a zero here would fake an scl edge
            q.scl_q <= LINE_IDLE;
            q.sda_q <= LINE_IDLE;
            q.sfs   <= SFS_RST;
            q.omc   <= OMC_RST;
            q.gvc   <= GVC_RST;
            q.dtc   <= DTC_RST;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // dac routing; index 0..3 is dac a..d
    always_comb begin
        dac_route[0] = SRC_CVBS;
        dac_route[1] = SRC_BLUE_U;
        dac_route[2] = SRC_RED_V;
        dac_route[3] = SRC_GREEN_Y;
        if (q.dtc[DAC_SW_B]) begin                                // R16
            dac_route[0] = SRC_GREEN_Y;
            dac_route[3] = SRC_CVBS;
        end
        if (i_yuv_mode) begin                                     // R17
            dac_route[3] = q.dtc[DAC4_B] ? SRC_CHROMA : SRC_CVBS;
        end
    end

    // power-down bits are not in dac order in the register
    assign dac_pd = {q.omc[PD_D_B], q.omc[PD_C_B],
                     q.omc[PD_B_B], q.omc[PD_A_B]};              // R3

    for (genvar g = 0; g < 4; g++) begin : g_dac
        vec_dac_slot u_slot (
            .i_clk        (i_clk),
            .i_sys_rst    (i_sys_rst),
            .i_src        (dac_route[g]),
            .i_power_down (dac_pd[g]),
            .o_src        (o_dac_src[g]),
            .o_power_on   (o_dac_power_on[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    assign o_sda_out          = SDA_LOW;
    assign o_sda_oe           = q.sda_oe;
    assign o_scr_pin_out      = PIN_IDLE;
    assign o_scr_pin_oe       = q.pin_oe;
    // mode 0 asks continuously; nothing is asked while disabled
    assign o_ttx_request      = ttx_en &                          // R19
                                (q.dtc[TTX_MODE_B] ? i_ttx_bit_req : 1'b1);
    assign o_ttx_data         = q.ttx_data;
    assign o_interlace_en     = q.interlace;
    assign o_caption_odd      = q.cap_odd;
    assign o_caption_even     = q.cap_even;
    assign o_color_bar_en     = q.omc[COLOR_BAR_B];               // R5
    assign o_bar_levels       = is_ntsc ?
                                {LVL_7P5, LVL_75, LVL_7P5, LVL_75} :
                                {LVL_0, LVL_75, LVL_0, LVL_100};  // R5
    assign o_master_mode      = q.master;
    assign o_square_pixel     = q.square;
    assign o_subcarrier_reset = q.sc_reset;
    assign o_rtc_valid        = q.rtc_valid;
    assign o_rtc_data         = q.rtc_data;
    assign o_active_pixels    = ~q.gvc[LINE_LEN_B] ? PIX_DIGITAL :
                                is_ntsc ? PIX_AN_NTSC : PIX_AN_PAL; // R11
    assign o_chroma_en        = q.gvc[CHROMA_B];                  // R12
    assign o_burst_en         = q.gvc[BURST_B];                   // R13
    assign o_vbi_pass         = q.dtc[VBI_B];                     // R15
    assign o_zero_is_black    = q.dtc[DEF_COLOR_B];               // R20

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence seq_pin_high;
        i_scr_pin && gl_input && !gl_type;
    endsequence
    sequence seq_pin_low;
        !i_scr_pin && gl_input && !gl_type;
    endsequence

    AST_INTERLACE_GATED: assert property ( // R1
        !i_composite_mode |=> !o_interlace_en)
        else $error("interlace active outside composite mode");
    AST_CAPTION_BOTH: assert property ( // R2
        (cap_sel == CAP_BOTH) |=> (o_caption_odd && o_caption_even))
        else $error("caption both fields not honoured");
    AST_BAR_MASTER: assert property ( // R6
        o_color_bar_en |=> o_master_mode)
        else $error("colour bars without master timing");
    AST_SQUARE_SLAVE: assert property ( // R7
        o_square_pixel |-> !o_master_mode)
        else $error("square pixel in master mode");
    AST_PIN_INPUT: assert property ( // R8
        gl_input |=> !o_scr_pin_oe)
        else $error("genlock pin driven while input");
    AST_SC_RESET: assert property ( // R9
        seq_pin_high ##1 seq_pin_low |=> o_subcarrier_reset)
        else $error("subcarrier reset missed on falling pin");
    AST_RTC_NO_RESET: assert property ( // R10
        gl_type |=> (!o_subcarrier_reset && (o_rtc_valid == $past(gl_input))))
        else $error("pin not treated as real-time control");
    AST_PIXELS: assert property ( // R11
        $rose(q.gvc[LINE_LEN_B]) && is_ntsc && $stable(q.sfs)
        |-> (o_active_pixels == PIX_AN_NTSC) && $past(o_active_pixels ==
        PIX_DIGITAL))
        else $error("active line length wrong");
    AST_TTX_OFF: assert property ( // R18
        !ttx_en |=> !o_ttx_data)
        else $error("teletext inserted while disabled");
    AST_TTX_REQ_HIGH: assert property ( // R19
        (ttx_en && !q.dtc[TTX_MODE_B]) [*2] |-> o_ttx_request)
        else $error("continuous teletext request dropped");

endmodule // vec_mode_ctrl
`default_nettype wire

// ==== verification/vec_host_model.sv ====
// host model on the two-wire register port
// assumes: pull-up on sda outside, scl high 4 clocks and low 6 clocks per bit
`timescale 1ns/1ps
`default_nettype none
module vec_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h6a
) (
    input  wire logic i_clk,
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda_pull
);
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // also used as repeated start
    task automatic start();
        o_sda_pull <= 1'b0;
        wt(2);
        o_scl <= 1'b1;
        wt(4);
        o_sda_pull <= 1'b1;
        wt(4);
        o_scl <= 1'b0;
        wt(2);
    endtask
    task automatic stop();
        o_sda_pull <= 1'b1;
        wt(2);
        o_scl <= 1'b1;
        wt(4);
        o_sda_pull <= 1'b0;
        wt(4);
    endtask
    task automatic bit_io(input logic b, output logic r);
        o_sda_pull <= ~b;
        wt(4);
        o_scl <= 1'b1;
        wt(4);
        r = i_sda_line;
        o_scl <= 1'b0;
        wt(2);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic byte_io(input logic [7:0] d, input logic m_ack,
                           output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(~m_ack, r);
        ack = ~r;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                             output logic ok);
        logic [7:0] q;
        logic [2:0] k;
        start();
        byte_io({DEV_ADDR, 1'b0}, 1'b0, q, k[0]);
        byte_io(a, 1'b0, q, k[1]);
        byte_io(d, 1'b0, q, k[2]);
        stop();
        ok = &k;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] q;
        logic k;
        start();
        byte_io({DEV_ADDR, 1'b0}, 1'b0, q, k);
        byte_io(a, 1'b0, q, k);
        start();
        byte_io({DEV_ADDR, 1'b1}, 1'b0, q, k);
        // released byte with host nack ends the read
        byte_io(8'hff, 1'b0, d, k);
        stop();
    endtask
endmodule // vec_host_model
`default_nettype wire

// ==== verification/vec_mode_ctrl_tb_top.sv ====
// self-checking bench for the mode-control register bank
// assumes: host model on the serial port, pull-up on sda
`timescale 1ns/1ps
`default_nettype none
module vec_mode_ctrl_tb_top
    import vec_pkg::*;
;
    localparam logic [1:0] REV = 2'h2; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic comp = 1'b0, yuv = 1'b0, mst = 1'b0, scr = 1'b1;
    logic teletext_input_pin = 1'b0, breq = 1'b0, scl, pull, sda_oe, scr_oe, treq;
    logic tdat, il, cod, cev, cbar, mm, sq, scres, rv, rtc, sdo, spo;
    logic ch, bu, vbi, zb;
    logic [3:0][2:0] src;
    logic [3:0]      pon;
    logic [3:0][9:0] bars;
    logic [9:0]      pix;
    int err_total = 0;
    int compares = 0;
    wire sda = ~(pull | sda_oe);
    always #50 clk = ~clk;
    vec_host_model HOST (.i_clk(clk), .i_sda_line(sda), .o_scl(scl),
        .o_sda_pull(pull));
    vec_mode_ctrl #(.REV_CODE(REV)) DUT (.i_clk(clk), .i_sys_rst(rst),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sdo), .o_sda_oe(sda_oe),
        .i_composite_mode(comp), .i_yuv_mode(yuv), .i_master_select(mst),
        .i_scr_pin(scr), .o_scr_pin_out(spo), .o_scr_pin_oe(scr_oe),
        .i_ttx_pin(teletext_input_pin), .i_ttx_bit_req(breq), .o_ttx_request(treq),
        .o_ttx_data(tdat), .o_interlace_en(il), .o_caption_odd(cod),
        .o_caption_even(cev), .o_dac_src(src), .o_dac_power_on(pon),
        .o_color_bar_en(cbar), .o_bar_levels(bars), .o_master_mode(mm),
        .o_square_pixel(sq), .o_subcarrier_reset(scres),
        .o_rtc_valid(rv), .o_rtc_data(rtc), .o_active_pixels(pix),
        .o_chroma_en(ch), .o_burst_en(bu), .o_vbi_pass(vbi),
        .o_zero_is_black(zb));
    ////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (err_total == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(string n, logic [39:0] s, logic [39:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic ok;
        HOST.write_reg(a, d, ok);
        chk("ack", ok, 1'b1);
        settle();
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        logic [7:0] q;
        HOST.read_reg(a, q);
        chk("read", q, e);
    endtask
    task automatic fall(output int n);
        n = 0;
        @(posedge clk) scr <= 1'b1;
        settle();
        @(posedge clk) scr <= 1'b0;
        repeat (6) begin
            @(negedge clk);
            if (scres !== 1'b0)
                n++;
        end
    endtask
    task automatic t_reset();
        chk("scr_oe", scr_oe, 1'b1);
        chk("pix", pix, PIX_DIGITAL);
        chk("pon", pon, 4'hf);
        chk("src", src, {SRC_GREEN_Y, SRC_RED_V, SRC_BLUE_U, SRC_CVBS});
        chk("pin_out", {sdo, spo}, 2'b00);
        rd(SUB_OMC, OMC_RST);
        rd(SUB_DTC, {6'h00, REV});
    endtask
    task automatic t_mr1();
        logic [7:0] pd [4] = '{8'h40, 8'h20, 8'h08, 8'h10};
        wr(SUB_OMC, 8'h01);
        chk("interlace", il, 1'b0);
        @(posedge clk) comp <= 1'b1;
        settle();
        chk("interlace", il, 1'b1);
        for (int c = 0; c < 4; c++) begin
            wr(SUB_OMC, 8'(c << CAP_LO));
            chk("cap_odd", cod, c[0]);
            chk("cap_even", cev, c[1]);
        end
        for (int i = 0; i < 4; i++) begin
            wr(SUB_OMC, pd[i]);
            chk("pon", pon, 4'(~(4'h1 << i)));
        end
    endtask
    task automatic t_bars();
        wr(SUB_GVC, 8'h01);
        chk("square", sq, 1'b1);
        wr(SUB_OMC, 8'h80);
        chk("bar", cbar, 1'b1);
        chk("master", mm, 1'b1);
        chk("square", sq, 1'b0);
        chk("bars", bars, {LVL_7P5, LVL_75, LVL_7P5, LVL_75});
        wr(SUB_SFS, 8'h01);
        chk("bars", bars, {LVL_0, LVL_75, LVL_0, LVL_100});
        wr(SUB_OMC, 8'h00);
        @(posedge clk) mst <= 1'b1;
        settle();
        chk("square", sq, 1'b0);
    endtask
    task automatic t_genlock();
        int n;
        wr(SUB_GVC, 8'h02);
        chk("scr_oe", scr_oe, 1'b0);
        fall(n);
        chk("scres", n, 1);
        wr(SUB_GVC, 8'h06);
        fall(n);
        chk("scres", n, 0);
        chk("rtc_valid", rv, 1'b1);
        chk("rtc", rtc, 1'b0);
        @(posedge clk) scr <= 1'b1;
        settle();
        chk("rtc", rtc, 1'b1);
    endtask
    task automatic t_line();
        // standard first, so the line-length switch is seen in ntsc
        wr(SUB_SFS, 8'h00);
        wr(SUB_GVC, 8'h08);
        chk("pix", pix, PIX_AN_NTSC);
        wr(SUB_SFS, 8'h01);
        chk("pix", pix, PIX_AN_PAL);
        wr(SUB_GVC, 8'h10);
        chk("pix", pix, PIX_DIGITAL);
        chk("chroma", {ch, bu}, 2'b10);
        wr(SUB_GVC, 8'h20);
        chk("chroma", {ch, bu}, 2'b01);
    endtask
    task automatic t_mr3();
        wr(SUB_DTC, 8'hff);
        rd(SUB_DTC, {6'h3f, REV});
        chk("vbi_black", {vbi, zb}, 2'b11);
        wr(SUB_DTC, 8'h08);
        chk("src", src, {SRC_CVBS, SRC_RED_V, SRC_BLUE_U, SRC_GREEN_Y});
        chk("vbi_black", {vbi, zb}, 2'b00);
        @(posedge clk) yuv <= 1'b1;
        wr(SUB_DTC, 8'h10);
        chk("src", src, {SRC_CHROMA, SRC_RED_V, SRC_BLUE_U, SRC_CVBS});
        wr(SUB_DTC, 8'h00);
        chk("src", src, {SRC_CVBS, SRC_RED_V, SRC_BLUE_U, SRC_CVBS});
        @(posedge clk) teletext_input_pin <= 1'b1;
        settle();
        chk("ttx", {treq, tdat}, 2'b00);
        wr(SUB_DTC, 8'h20);
        chk("ttx", {treq, tdat}, 2'b11);
        @(posedge clk) teletext_input_pin <= 1'b0;
        @(negedge clk);
        chk("ttx_late", tdat, 1'b1);
        @(negedge clk);
        chk("ttx_late", tdat, 1'b0);
        wr(SUB_DTC, 8'h60);
        chk("ttx_req", treq, 1'b0);
        @(posedge clk) breq <= 1'b1;
        @(negedge clk);
        chk("ttx_req", treq, 1'b1);
    endtask
    // watchdog: run needs about 8950 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        settle();
        t_reset();
        t_mr1();
        t_bars();
        t_genlock();
        t_line();
        t_mr3();
        give_verdict();
    end
endmodule // vec_mode_ctrl_tb_top
`default_nettype wire
